// file: ssp_host_model.sv
/*
  Host side model: an APB master that issues single transfers to the
  parameter block. Assumes the bench clock and a slave driving pready.
*/
`timescale 1ns/1ps
module ssp_host_model (
  // clock
  input  wire logic        clk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // ------------------------------------------------------------
  // one transfer: setup, access, wait for pready, release
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    ok = (pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule

// file: ssp_param_block.sv
/*
  Sensor status parameter block: status banks, timestamp image, physical
  sensor status image and presence bitmap, read over APB, plus a sticky
  interrupt status. Assumes inputs synchronous to clk and an APB master.
*/
// Summary of operation
// - sixteen status bytes per bank; byte n of bank b is type 16b+n+1
// - type zero has no status byte; updates for it are dropped
// - status bits 0..4: data waiting, no ack, identity error, transient, lost
// - status bits 5..7 carry the sensor power state code
// - timestamp bytes 0..3: system time at last host interrupt, LSB first
// - timestamp bytes 4..7: current system time, LSB first, read only
// - interrupt time also readable from four dedicated byte registers
// - physical image starts with accel rate, range, flags
// - physical flags: bit 0 interrupt enable, bits 5..7 power state
// - gyro rate bytes 5-6, range 7-8, flags byte 9
// - mag rate bytes 10-11, range 12-13, flags byte 14
// - presence bitmap bit k set when physical sensor k present
// - banks 0-1 hold non-wakeup sensors, banks 2-3 wakeup sensors
`timescale 1ns/1ps
module ssp_param_block
  import ssp_pkg::*;
#(
  parameter int unsigned CLK_HZ  = SSP_CLK_HZ,
  parameter int unsigned TICK_HZ = SSP_TICK_HZ
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // status byte updates
  input  wire logic        statUpdValid,
  input  wire logic [6:0]  statUpdType,
  input  wire logic [4:0]  statUpdFlags,
  input  wire logic [2:0]  statUpdPower,
  // physical sensors: accel, gyro, mag
  input  wire logic [47:0] physRate,
  input  wire logic [47:0] physRange,
  input  wire logic [2:0]  physIrqEn,
  input  wire logic [63:0] physPresent,
  // host interrupt and block interrupt
  input  wire logic        hostIrq,
  output logic             irq
);

  localparam logic [SSP_ACC_W-1:0] AccStep = SSP_ACC_W'(TICK_HZ);
  localparam logic [SSP_ACC_W-1:0] AccWrap = SSP_ACC_W'(CLK_HZ - TICK_HZ);

  logic [0:0]           ctrlQ;
  logic [SSP_NEV-1:0]   intStatQ;
  logic [SSP_NEV-1:0]   intMaskQ;
  logic [SSP_NEV-1:0]   evSet;
  logic [SSP_ACC_W-1:0] accQ;
  logic                 tick;
  logic [31:0]          sysTimeQ;
  logic [31:0]          hostIrqTimeQ;
  logic                 hostIrqPrevQ;
  logic                 hostIrqRise;
  logic [47:0]          rateQ;
  logic [47:0]          rangeQ;
  logic [2:0]           irqEnQ;
  logic [2:0]           physPowQ [3];
  logic [63:0]          presMapQ;
  logic [127:0]         physImg;
  logic                 memWrEn;
  logic [3:0]           memWrAddr;
  logic [3:0]           memWrByteEn;
  logic [31:0]          memWrData;
  logic [31:0]          memRdData;
  logic [6:0]           typeIdx;
  logic                 rdAccess;
  logic                 wrAccess;

  function automatic logic inBank(input logic [11:0] a);
    return a >= SSP_BANK_ADDR && a <= SSP_BANK_LAST;
  endfunction

  function automatic logic inIrqt(input logic [11:0] a);
    return a >= SSP_IRQT_ADDR && a <= SSP_IRQT_ADDR + 12'h00c;
  endfunction

  // ----------------------------------------------------------------
  // 32 kHz tick and system time
  // ----------------------------------------------------------------
  assign tick = ctrlQ[SSP_CTRL_RUN] && accQ >= AccWrap;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      accQ <= '0;
    else if (tick)
      accQ <= accQ - AccWrap;
    else if (ctrlQ[SSP_CTRL_RUN])
      accQ <= accQ + AccStep;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sysTimeQ <= 32'h0;
    else if (tick)
      sysTimeQ <= sysTimeQ + 32'h1;
  end

  // ----------------------------------------------------------------
  // host interrupt time capture
  // ----------------------------------------------------------------
  assign hostIrqRise = hostIrq && !hostIrqPrevQ;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hostIrqPrevQ <= 1'b0;
      hostIrqTimeQ <= 32'h0;
    end
    else
    begin
      hostIrqPrevQ <= hostIrq;
      if (hostIrqRise)
        hostIrqTimeQ <= sysTimeQ;
    end
  end

  // ----------------------------------------------------------------
  // status banks
  // ----------------------------------------------------------------
  assign typeIdx     = statUpdType - 7'h1;
  assign memWrEn     = statUpdValid && statUpdType != 7'h0
                       && statUpdType <= 7'd64;
  assign memWrAddr   = typeIdx[5:2];
  assign memWrByteEn = 4'h1 << typeIdx[1:0];
  assign memWrData   = {4{statUpdPower, statUpdFlags}};

  ssp_status_mem #(
    .DEPTH (4 * SSP_BANK_BYTES / 4),
    .WIDTH (32),
    .AW    (4)
  ) u_mem (
    .clk      (clk),
    .resetn   (resetn),
    .wrEn     (memWrEn),
    .wrAddr   (memWrAddr),
    .wrByteEn (memWrByteEn),
    .wrData   (memWrData),
    .rdAddr   (paddr[5:2]),
    .rdData   (memRdData)
  );

  // ----------------------------------------------------------------
  // physical sensor image and presence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rateQ    <= '0;
      rangeQ   <= '0;
      irqEnQ   <= '0;
      presMapQ <= '0;
    end
    else
    begin
      rateQ    <= physRate;
      rangeQ   <= physRange;
      irqEnQ   <= physIrqEn;
      presMapQ <= physPresent;
    end
  end

  for (genvar s = 0; s < 3; s++)
  begin : g_phys
    localparam logic [6:0] PType = (s == 0) ? SSP_TYPE_ACC :
                                   (s == 1) ? SSP_TYPE_GYR : SSP_TYPE_MAG;
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        physPowQ[s] <= SSP_POW_ABSENT;
      else if (memWrEn && statUpdType == PType)
        physPowQ[s] <= statUpdPower;
    end
    // five bytes per sensor: rate, range, flags
    assign physImg[40*s +: 40] = {physPowQ[s], 4'h0, irqEnQ[s],
                                  rangeQ[16*s +: 16],
                                  rateQ[16*s +: 16]};
  end
  assign physImg[127:120] = 8'h00;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  assign rdAccess = psel && penable && !pwrite;
  assign wrAccess = psel && penable && pwrite;

  assign evSet[SSP_EV_HOSTIRQ] = hostIrqRise;
  assign evSet[SSP_EV_LOST]    = memWrEn && statUpdFlags[SSP_FLG_LOST];
  assign evSet[SSP_EV_WAKE]    = memWrEn && statUpdType >= SSP_WAKE_TYPE;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      intStatQ <= SSP_ISTAT_RST;
    else if (wrAccess && paddr == SSP_ISTAT_ADDR)
      intStatQ <= (intStatQ & ~pwdata[SSP_NEV-1:0]) | evSet;
    else
      intStatQ <= intStatQ | evSet;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      intMaskQ <= SSP_IMASK_RST;
      ctrlQ    <= SSP_CTRL_RST;
    end
    else if (wrAccess && paddr == SSP_IMASK_ADDR)
      intMaskQ <= pwdata[SSP_NEV-1:0];
    else if (wrAccess && paddr == SSP_CTRL_ADDR)
      ctrlQ    <= pwdata[0:0];
  end

  assign irq = |(intStatQ & intMaskQ);

  // ----------------------------------------------------------------
  // apb read mux
  // ----------------------------------------------------------------
  assign pready = 1'b1;

  always_comb
  begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    if (psel && penable)
    begin
      if (paddr == SSP_CTRL_ADDR)
        prdata = {31'h0, ctrlQ};
      else if (paddr == SSP_ISTAT_ADDR)
        prdata = {29'h0, intStatQ};
      else if (paddr == SSP_IMASK_ADDR)
        prdata = {29'h0, intMaskQ};
      else if (inBank(paddr))
        prdata = memRdData;
      else if (paddr == SSP_TS_ADDR)
        prdata = hostIrqTimeQ;
      else if (paddr == SSP_TS_ADDR + 12'h004)
        prdata = sysTimeQ;
      else if (paddr[11:4] == SSP_PHYS_ADDR[11:4])
        prdata = physImg[32*paddr[3:2] +: 32];
      else if (paddr == SSP_PRES_ADDR)
        prdata = presMapQ[31:0];
      else if (paddr == SSP_PRES_ADDR + 12'h004)
        prdata = presMapQ[63:32];
      else if (inIrqt(paddr))
        prdata = {24'h0, hostIrqTimeQ[8*paddr[3:2] +: 8]};
      else
        pslverr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence rdTsNow;
    psel && !penable && !pwrite && paddr == SSP_TS_ADDR + 12'h004
    ##1 rdAccess;
  endsequence

  chk_time_tick: assert property (
    tick |=> sysTimeQ == $past(sysTimeQ) + 32'h1)
    else $error("system time did not advance on tick");

  chk_tick_spacing: assert property (
    tick |=> !tick [*8])
    else $error("tick pulses too close");

  chk_irq_capture: assert property (
    $rose(hostIrq) |=> hostIrqTimeQ == $past(sysTimeQ))
    else $error("host interrupt time not captured");

  chk_ts_now_read: assert property (
    rdTsNow |-> prdata == sysTimeQ && !pslverr)
    else $error("current time image wrong");

  chk_irqt_byte: assert property (
    rdAccess && paddr == SSP_IRQT_ADDR + 12'h008
    |-> prdata == {24'h0, hostIrqTimeQ[23:16]})
    else $error("interrupt time byte register wrong");

  chk_type_zero: assert property (
    statUpdValid && statUpdType == 7'h0 |-> !memWrEn)
    else $error("type zero status written");

  chk_stat_lane: assert property (
    memWrEn && statUpdType == 7'd64
    |-> memWrAddr == 4'hf && memWrByteEn == 4'h8)
    else $error("type 64 not in last byte of bank 3");

  chk_stat_byte: assert property (
    memWrEn && memWrByteEn == 4'h1
    |=> u_mem.memQ[$past(memWrAddr)][7:0]
        == $past({statUpdPower, statUpdFlags}))
    else $error("status byte layout wrong");

  chk_phys_flags: assert property (
    memWrEn && statUpdType == SSP_TYPE_GYR
    |=> ##1 physImg[79:77] == $past(statUpdPower, 2))
    else $error("gyro flags power copy wrong");

  chk_pres_map: assert property (
    resetn |=> presMapQ == $past(physPresent))
    else $error("presence bitmap not tracked");

  chk_irq_event: assert property (
    hostIrqRise && intMaskQ[SSP_EV_HOSTIRQ] |=> irq [*2])
    else $error("interrupt not raised on host irq");

endmodule

// file: ssp_pkg.sv
/*
  Shared constants of the sensor status parameter block: the register map
  of the APB slave, field positions, reset values and the tick timing.
  Assumes a 250 MHz system clock and a 12-bit APB byte address.
*/
package ssp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SSP_CLK_HZ  = 250000000;
  localparam int unsigned SSP_TICK_HZ = 32000;
  localparam int unsigned SSP_ACC_W   = 28;

  // ----------------------------------------------------------------
  // register offsets (byte addresses; SSP_IRQT_IDX is a word index)
  // ----------------------------------------------------------------
  localparam logic [11:0] SSP_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] SSP_ISTAT_ADDR  = 12'h004;
  localparam logic [11:0] SSP_IMASK_ADDR  = 12'h008;
  localparam logic [11:0] SSP_BANK_ADDR   = 12'h100;
  localparam logic [11:0] SSP_BANK_LAST   = 12'h13c;
  localparam logic [11:0] SSP_TS_ADDR     = 12'h140;
  localparam logic [11:0] SSP_PHYS_ADDR   = 12'h150;
  localparam logic [11:0] SSP_PRES_ADDR   = 12'h160;
  localparam logic [9:0]  SSP_IRQT_IDX    = 10'h06c;
  localparam logic [11:0] SSP_IRQT_ADDR   = {SSP_IRQT_IDX, 2'b00};

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SSP_CTRL_RUN     = 0;
  localparam logic [0:0]  SSP_CTRL_RST     = 1'h1;
  localparam int unsigned SSP_NEV          = 3;
  localparam int unsigned SSP_EV_HOSTIRQ   = 0;
  localparam int unsigned SSP_EV_LOST      = 1;
  localparam int unsigned SSP_EV_WAKE      = 2;
  localparam logic [2:0]  SSP_ISTAT_RST    = 3'h0;
  localparam logic [2:0]  SSP_IMASK_RST    = 3'h0;
  localparam int unsigned SSP_FLG_AVAIL    = 0;
  localparam int unsigned SSP_FLG_NOACK    = 1;
  localparam int unsigned SSP_FLG_IDERR    = 2;
  localparam int unsigned SSP_FLG_TRANS    = 3;
  localparam int unsigned SSP_FLG_LOST     = 4;
  localparam int unsigned SSP_POW_LSB      = 5;
  localparam int unsigned SSP_BANK_BYTES   = 16;
  localparam logic [6:0]  SSP_WAKE_TYPE    = 7'h21;
  localparam logic [6:0]  SSP_TYPE_ACC     = 7'h01;
  localparam logic [6:0]  SSP_TYPE_MAG     = 7'h02;
  localparam logic [6:0]  SSP_TYPE_GYR     = 7'h04;

  typedef enum logic [2:0] {
    SSP_POW_ABSENT  = 3'h0,
    SSP_POW_DOWN    = 3'h1,
    SSP_POW_SUSPEND = 3'h2,
    SSP_POW_SELFTST = 3'h3,
    SSP_POW_MOTION  = 3'h4,
    SSP_POW_ONESHOT = 3'h5,
    SSP_POW_LOWPWR  = 3'h6,
    SSP_POW_ACTIVE  = 3'h7
  } ssp_power_t;

endpackage

// file: ssp_status_mem.sv
/*
  Small word memory holding the status banks, with byte-lane writes and a
  registered read port. Assumes one clock and an active-low async reset.
*/
`timescale 1ns/1ps
module ssp_status_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned WIDTH = 32,
  parameter int unsigned AW    = 4
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // write port
  input  wire logic               wrEn,
  input  wire logic [AW-1:0]      wrAddr,
  input  wire logic [WIDTH/8-1:0] wrByteEn,
  input  wire logic [WIDTH-1:0]   wrData,
  // read port
  input  wire logic [AW-1:0]      rdAddr,
  output logic      [WIDTH-1:0]   rdData
);

  logic [WIDTH-1:0] memQ [DEPTH];

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  for (genvar w = 0; w < DEPTH; w++)
  begin : g_word
    for (genvar b = 0; b < WIDTH/8; b++)
    begin : g_lane
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          memQ[w][8*b +: 8] <= 8'h00;
        else if (wrEn && wrByteEn[b] && wrAddr == AW'(w))
          memQ[w][8*b +: 8] <= wrData[8*b +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // registered read
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdData <= '0;
    else
      rdData <= memQ[rdAddr];
  end

endmodule

// file: tb.sv
/*
  Testbench of the sensor status parameter block: status banks, time
  images, physical image, presence map and interrupts, read over APB.
  Assumes the host model for bus cycles and a fast tick parameter.
*/
`timescale 1ns/1ps
module tb
  import ssp_pkg::*;
;
  logic         clk = 1'b0;
  logic         resetn;
  logic         psel, penable, pwrite, pready, pslverr, irq, err;
  logic  [11:0] paddr;
  logic  [31:0] pwdata, prdata, d, c0, c1;
  logic         statUpdValid, hostIrq;
  logic   [6:0] statUpdType;
  logic   [4:0] statUpdFlags;
  logic   [2:0] statUpdPower, physIrqEn;
  logic  [47:0] physRate, physRange;
  logic  [63:0] physPresent;
  logic   [7:0] expB [0:63];
  logic [127:0] pv;
  int           fail_count = 0;
  int           cmp_count = 0;
  int           i;

  always #2 clk = ~clk;

  ssp_param_block #(.CLK_HZ(250000000), .TICK_HZ(25000000))
    u_ssp_param_block (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .statUpdValid(statUpdValid), .statUpdType(statUpdType),
    .statUpdFlags(statUpdFlags), .statUpdPower(statUpdPower),
    .physRate(physRate), .physRange(physRange), .physIrqEn(physIrqEn),
    .physPresent(physPresent), .hostIrq(hostIrq), .irq(irq));

  ssp_host_model u_ssp_host_model (.clk(clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    logic ok;
    u_ssp_host_model.xfer(w, a, wd, r, err, ok);
    if (!ok)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic upd(input int t, input logic [4:0] f,
                     input logic [2:0] p);
    @(posedge clk);
    statUpdValid <= 1'b1;
    statUpdType <= 7'(t);
    statUpdFlags <= f;
    statUpdPower <= p;
    @(posedge clk);
    statUpdValid <= 1'b0;
    statUpdType <= ~7'(t);
    if (t >= 1 && t <= 64)
      expB[t-1] = {p, f};
  endtask

  task automatic banks();
    for (int w = 0; w < 16; w++)
    begin
      acc(1'b0, SSP_BANK_ADDR + 12'(w*4), 32'h0, d);
      check(d, {expB[4*w+3], expB[4*w+2], expB[4*w+1], expB[4*w]});
    end
  endtask

  task automatic irqat(input logic x);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, x});
  endtask

  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    statUpdValid = 1'b0;
    statUpdType = 7'h0;
    statUpdFlags = 5'h0;
    statUpdPower = 3'h0;
    physRate = 48'h003c_00c8_0190;
    physRange = 48'h04b0_07d0_0010;
    physIrqEn = 3'h5;
    physPresent = 64'h8000_0000_0000_1006;
    hostIrq = 1'b0;
    for (i = 0; i < 64; i++)
      expB[i] = 8'h0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    acc(1'b0, SSP_CTRL_ADDR, 32'h0, d);
    check(d, 32'h1);
    acc(1'b0, SSP_ISTAT_ADDR, 32'h0, d);
    check(d, 32'h0);
    acc(1'b0, SSP_IMASK_ADDR, 32'h0, d);
    check(d, 32'h0);
    banks();
    // boundary types, every power code and every flag bit
    for (i = 0; i < 8; i++)
      upd(i + 2, 5'h1 << (i % 5), 3'(i));
    upd(1, 5'h11, SSP_POW_ACTIVE);
    upd(16, 5'h0a, SSP_POW_SUSPEND);
    upd(17, 5'h04, SSP_POW_DOWN);
    upd(33, 5'h01, SSP_POW_MOTION);
    upd(64, 5'h1f, SSP_POW_ONESHOT);
    upd(0, 5'h1f, 3'h7);
    upd(65, 5'h1f, 3'h7);
    banks();
    // sticky status, mask and clear
    acc(1'b0, SSP_ISTAT_ADDR, 32'h0, d);
    check(d, 32'h6);
    irqat(1'b0);
    acc(1'b1, SSP_IMASK_ADDR, 32'h2, d);
    irqat(1'b1);
    acc(1'b1, SSP_ISTAT_ADDR, 32'h2, d);
    irqat(1'b0);
    acc(1'b0, SSP_ISTAT_ADDR, 32'h0, d);
    check(d, 32'h4);
    acc(1'b1, SSP_IMASK_ADDR, 32'h1, d);
    // host interrupt time capture
    acc(1'b0, SSP_TS_ADDR + 12'h4, 32'h0, c0);
    @(posedge clk);
    hostIrq <= 1'b1;
    repeat (3) @(posedge clk);
    irqat(1'b1);
    acc(1'b0, SSP_TS_ADDR, 32'h0, c1);
    check({31'h0, (c1 - c0) <= 32'h1}, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      acc(1'b0, SSP_IRQT_ADDR + 12'(i*4), 32'h0, d);
      check(d, {24'h0, c1[8*i +: 8]});
    end
    // current time advances one tick per ten cycles
    acc(1'b0, SSP_TS_ADDR + 12'h4, 32'h0, c0);
    repeat (100) @(posedge clk);
    acc(1'b0, SSP_TS_ADDR + 12'h4, 32'h0, c1);
    check({31'h0, (c1 - c0) inside {[10:11]}}, 32'h1);
    // stopped counter, read-only image
    acc(1'b1, SSP_CTRL_ADDR, 32'h0, d);
    acc(1'b0, SSP_TS_ADDR + 12'h4, 32'h0, c0);
    acc(1'b1, SSP_TS_ADDR + 12'h4, 32'hffff_ffff, d);
    check({31'h0, err}, 32'h0);
    repeat (30) @(posedge clk);
    acc(1'b0, SSP_TS_ADDR + 12'h4, 32'h0, d);
    check(d, c0);
    acc(1'b1, SSP_CTRL_ADDR, 32'h1, d);
    // physical sensor image
    pv = {8'h0, {expB[1][7:5], 4'h0, physIrqEn[2]}, physRange[47:32],
          physRate[47:32], {expB[3][7:5], 4'h0, physIrqEn[1]},
          physRange[31:16], physRate[31:16],
          {expB[0][7:5], 4'h0, physIrqEn[0]}, physRange[15:0],
          physRate[15:0]};
    for (i = 0; i < 4; i++)
    begin
      acc(1'b0, SSP_PHYS_ADDR + 12'(i*4), 32'h0, d);
      check(d, pv[32*i +: 32]);
    end
    // presence map
    acc(1'b0, SSP_PRES_ADDR, 32'h0, d);
    check(d, 32'h0000_1006);
    acc(1'b0, SSP_PRES_ADDR + 12'h4, 32'h0, d);
    check(d, 32'h8000_0000);
    // unmapped address
    acc(1'b0, 12'h200, 32'h0, d);
    check({31'h0, err}, 32'h1);
    acc(1'b1, 12'h204, 32'h1, d);
    check({31'h0, err}, 32'h1);
    report_and_stop();
  end
endmodule
